// ### bench/soft_reset_command_register_tb.sv
// self-checking bench for the soft-reset command block
// assumes the host model drives the register port, the bench the rest
module soft_reset_command_register_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import srcr_pkg::*;
   typedef struct packed {
      logic sa; logic rd; logic [7:0] code; logic wdog; srcr_ch_state_t st; logic rst;
   } srcr_row_t;
   localparam srcr_row_t ROWS [7] = '{
      '{1'b1, 1'b0, RESET_CODE_LOAD,   1'b0, SRCR_CH_LOAD,   1'b1},
      '{1'b1, 1'b1, RESET_CODE_DETECT, 1'b1, SRCR_CH_DETECT, 1'b1},
      '{1'b0, 1'b0, RESET_CODE_LOAD,   1'b0, SRCR_CH_RUN,    1'b1},
      '{1'b0, 1'b1, RESET_CODE_DETECT, 1'b1, SRCR_CH_RUN,    1'b1},
      '{1'b1, 1'b0, RESET_CODE_LOAD,   1'b0, SRCR_CH_LOAD,   1'b1},
      '{1'b1, 1'b0, RESET_CODE_DETECT, 1'b1, SRCR_CH_RUN,    1'b1},
      '{1'b1, 1'b0, 8'ha5,             1'b1, SRCR_CH_RUN,    1'b0}};
   logic clk = 1'b0, sys_rst = 1'b1, stand_alone = 1'b0, wdt_timeout = 1'b0;
   logic wr_en, rd_en, watchdog_enable;
   logic [1:0] run_req = 2'b00;
   logic [7:0] addr, wdata, rdata, rd;
   logic [5:0] ch1_on_time, ch2_on_time, exp_ot;
   srcr_ch_state_t ch1_state, ch2_state;
   int fails = 0, num_checks = 0;
   srcr_top u_srcr_top (.clk(clk), .sys_rst(sys_rst), .wr_en(wr_en), .rd_en(rd_en),
      .addr(addr), .wdata(wdata), .rdata(rdata), .stand_alone(stand_alone),
      .wdt_timeout(wdt_timeout), .run_req(run_req), .watchdog_enable(watchdog_enable),
      .ch1_state(ch1_state), .ch2_state(ch2_state), .ch1_on_time(ch1_on_time),
      .ch2_on_time(ch2_on_time));
   srcr_host u_srcr_host (.clk(clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
      .wdata(wdata), .rdata(rdata));
   // free-running clock
   always #20 clk = ~clk;
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // hang guard
   initial begin
      repeat (3000) @(posedge clk);
      fails++;
      conclude();
   end
   // main sequence: table rows, then reset and status cases
   initial begin
      repeat (5) @(posedge clk);
      #1 sys_rst = 1'b0;
      foreach (ROWS[i]) begin
         stand_alone = ROWS[i].sa;
         run_req = 2'b11;
         repeat (2) @(posedge clk);
         #1 run_req = 2'b00;
         u_srcr_host.write(CH1_ON_TIME_ADDR, {2'b00, ON_TIME_2M23});
         u_srcr_host.write(CH2_ON_TIME_ADDR, {2'b00, ON_TIME_220K});
         if (ROWS[i].rd) u_srcr_host.restore_detect(rd);
         else u_srcr_host.write(SOFT_RESET_COMMAND_ADDR, ROWS[i].code);
         exp_ot = ROWS[i].rst ? ON_TIME_RST : ON_TIME_2M23;
         chk({7'h00, watchdog_enable}, {7'h00, ROWS[i].wdog});
         chk({6'h00, ch1_state}, {6'h00, ROWS[i].st});
         chk({6'h00, ch2_state}, {6'h00, ROWS[i].st});
         chk({2'b00, ch1_on_time}, {2'b00, exp_ot});
         chk({2'b00, ch2_on_time}, {2'b00, ROWS[i].rst ? ON_TIME_RST : ON_TIME_220K});
         $display("row %0d done", i);
      end
      // second reset in mid-run
      #1 sys_rst = 1'b1;
      #1 chk({rdata[7:1], watchdog_enable}, 8'h01);
      chk({ch1_state, ch2_state, ch1_on_time[3:0]}, {4'h0, ON_TIME_RST[3:0]});
      @(posedge clk);
      #1 sys_rst = 1'b0;
      $display("reset test done");
      u_srcr_host.read(THIRD_STATUS_ADDR, rd);
      chk(rd, 8'h80);
      @(posedge clk);
      #1 wdt_timeout = 1'b1;
      @(posedge clk);
      #1 wdt_timeout = 1'b0;
      u_srcr_host.read(THIRD_STATUS_ADDR, rd);
      chk(rd, 8'h03);
      u_srcr_host.read(THIRD_STATUS_ADDR, rd);
      chk(rd, 8'h00);
      u_srcr_host.write(SOFT_RESET_COMMAND_ADDR, RESET_CODE_LOAD);
      u_srcr_host.read(SOFT_RESET_COMMAND_ADDR, rd);
      chk(rd, 8'h00);
      u_srcr_host.read(THIRD_STATUS_ADDR, rd);
      chk(rd, 8'h00);
      $display("status test done");
      conclude();
   end
endmodule // soft_reset_command_register_tb

// ### bench/srcr_host.sv
// host model: byte accesses to the soft-reset block
// assumes strobes are taken on the rising edge of clk
module srcr_host (
   input  wire logic       clk,
   output logic            wr_en,
   output logic            rd_en,
   output logic [7:0]      addr,
   output logic [7:0]      wdata,
   input  wire logic [7:0] rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   import srcr_pkg::*;
   initial begin
      {wr_en, rd_en, addr, wdata} = 18'h0_0000;
   end
   // one write; afterwards the lines stop showing the old byte
   task automatic write(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #1 {addr, wdata, wr_en} = {a, d, 1'b1};
      @(posedge clk);
      #1 {addr, wdata, wr_en} = {~a, ~d, 1'b0};
   endtask
   // one read; the byte shows in the cycle after it is taken
   task automatic read(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      #1 {addr, rd_en} = {a, 1'b1};
      @(posedge clk);
      #1 {addr, rd_en} = {~a, 1'b0};
      d = rdata;
   endtask
   // return to detect: the status read must come first
   task automatic restore_detect(output logic [7:0] st);
      read(THIRD_STATUS_ADDR, st);
      write(SOFT_RESET_COMMAND_ADDR, RESET_CODE_DETECT);
   endtask
endmodule // srcr_host

// ### rtl/srcr_channel.sv
// one channel enable state machine with its on-time code
// assumes commands are single-cycle pulses from the register block
module srcr_channel
   import srcr_pkg::*;
(
   input  wire logic           clk,
   input  wire logic           sys_rst,
   input  wire logic           go_load,
   input  wire logic           go_detect,
   input  wire logic           run_req,
   input  wire logic           on_time_we,
   input  wire logic [5:0]     on_time_wdata,
   input  wire logic           regs_default,
   output srcr_pkg::srcr_ch_state_t state,
   output logic      [5:0]     on_time
);
   srcr_ch_state_t next_state;
   logic [5:0]     next_on_time;

   // next state: reset commands override normal progress
   always_comb begin
      next_state   = state;
      next_on_time = on_time;
      if (go_load) begin
         next_state = SRCR_CH_LOAD;
      end else if (go_detect) begin
         next_state = SRCR_CH_DETECT;
      end else if (run_req) begin
         next_state = SRCR_CH_RUN;
      end
      if (regs_default) begin
         next_on_time = ON_TIME_RST;
      end else if (on_time_we) begin
         next_on_time = on_time_wdata;
      end
   end

   // registers
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state   <= SRCR_CH_LOAD;
         on_time <= ON_TIME_RST;
      end else begin
         state   <= next_state;
         on_time <= next_on_time;
      end
   end
endmodule // srcr_channel

// ### rtl/srcr_pkg.sv
// package of constants for the soft-reset command block
// assumes a byte-wide register access port driven by the serial interface front end
package srcr_pkg;
   localparam logic [7:0] SOFT_RESET_COMMAND_ADDR = 8'h2e;
   localparam logic [7:0] THIRD_STATUS_ADDR       = 8'h2f;
   localparam logic [7:0] CH1_ON_TIME_ADDR        = 8'h30;
   localparam logic [7:0] CH2_ON_TIME_ADDR        = 8'h31;
   localparam logic [7:0] RESET_CODE_LOAD         = 8'hc3;
   localparam logic [7:0] RESET_CODE_DETECT       = 8'hd4;
   localparam logic [7:0] SOFT_RESET_RST          = 8'h00;
   localparam logic [5:0] ON_TIME_RST             = 6'h07;
   localparam logic [5:0] ON_TIME_220K            = 6'h03;
   localparam logic [5:0] ON_TIME_2M23            = 6'h2b;
   localparam int         PC_BIT                  = 7;
   localparam int         WDT_FLAG_LSB            = 0;
   localparam logic [1:0] WDT_FLAGS_RST           = 2'h0;
   typedef enum logic [1:0] {SRCR_CH_LOAD, SRCR_CH_DETECT, SRCR_CH_RUN} srcr_ch_state_t;
endpackage

// ### rtl/srcr_top.sv
// soft-reset command register with its reset targets
// assumes a synchronous byte register port: one-cycle wr_en or rd_en with addr
module srcr_top
   import srcr_pkg::*;
(
   input  wire logic           clk,
   input  wire logic           sys_rst,
   input  wire logic           wr_en,
   input  wire logic           rd_en,
   input  wire logic [7:0]     addr,
   input  wire logic [7:0]     wdata,
   output logic      [7:0]     rdata,
   input  wire logic           stand_alone,
   input  wire logic           wdt_timeout,
   input  wire logic [1:0]     run_req,
   output logic                watchdog_enable,
   output srcr_pkg::srcr_ch_state_t ch1_state,
   output srcr_pkg::srcr_ch_state_t ch2_state,
   output logic      [5:0]     ch1_on_time,
   output logic      [5:0]     ch2_on_time
);
   logic       [7:0] next_rdata;
   logic             next_watchdog_enable;
   logic       [1:0] command_watchdog_timeout_flags;
   logic       [1:0] next_flags;
   logic             power_cycle_indicator;
   logic             next_pc;
   logic             status_read_seen;
   logic             next_status_read_seen;
   logic             code_load;
   logic             code_detect;
   logic             regs_default;
   logic             status_rd;
   logic       [7:0] third_fault_status_reg;

   // command decode; any other value is ignored
   assign code_load    = wr_en && addr == SOFT_RESET_COMMAND_ADDR && wdata == RESET_CODE_LOAD;
   assign code_detect  = wr_en && addr == SOFT_RESET_COMMAND_ADDR && wdata == RESET_CODE_DETECT;
   assign regs_default = code_load || code_detect;
   assign status_rd    = rd_en && addr == THIRD_STATUS_ADDR;
   assign third_fault_status_reg = {power_cycle_indicator, 5'b0_0000,
                                    command_watchdog_timeout_flags};

   // status flags, watchdog enable and read data
   always_comb begin
      next_flags            = command_watchdog_timeout_flags;
      next_pc               = power_cycle_indicator;
      next_watchdog_enable  = watchdog_enable;
      next_status_read_seen = status_read_seen;
      next_rdata            = 8'h00;
      if (status_rd) begin
         next_flags            = WDT_FLAGS_RST;
         next_status_read_seen = 1'b1;
         next_pc               = 1'b0;
      end
      if (wdt_timeout) begin
         next_flags = 2'b11; // set wins over read clear
      end
      if (code_load) begin
         next_watchdog_enable  = 1'b0;
         next_status_read_seen = 1'b0;
      end else if (code_detect) begin
         next_watchdog_enable  = 1'b1;
         next_status_read_seen = 1'b0;
      end
      if (rd_en) begin
         if (addr == SOFT_RESET_COMMAND_ADDR) begin
            next_rdata = 8'h00;
         end else if (addr == THIRD_STATUS_ADDR) begin
            next_rdata = third_fault_status_reg;
         end else if (addr == CH1_ON_TIME_ADDR) begin
            next_rdata = {2'b00, ch1_on_time};
         end else if (addr == CH2_ON_TIME_ADDR) begin
            next_rdata = {2'b00, ch2_on_time};
         end else begin
            next_rdata = 8'h00;
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         command_watchdog_timeout_flags <= WDT_FLAGS_RST;
         power_cycle_indicator          <= 1'b1;
         watchdog_enable                <= 1'b1;
         status_read_seen               <= 1'b0;
         rdata                          <= SOFT_RESET_RST;
      end else begin
         command_watchdog_timeout_flags <= next_flags;
         power_cycle_indicator          <= next_pc;
         watchdog_enable                <= next_watchdog_enable;
         status_read_seen               <= next_status_read_seen;
         rdata                          <= next_rdata;
      end
   end

   // channel machines: detect needs prior status read in stand-alone mode
   srcr_channel u_ch1 (
      .clk           (clk),
      .sys_rst       (sys_rst),
      .go_load       (code_load && stand_alone),
      .go_detect     (code_detect && stand_alone && status_read_seen),
      .run_req       (run_req[0]),
      .on_time_we    (wr_en && addr == CH1_ON_TIME_ADDR),
      .on_time_wdata (wdata[5:0]),
      .regs_default  (regs_default),
      .state         (ch1_state),
      .on_time       (ch1_on_time)
   );
   srcr_channel u_ch2 (
      .clk           (clk),
      .sys_rst       (sys_rst),
      .go_load       (code_load && stand_alone),
      .go_detect     (code_detect && stand_alone && status_read_seen),
      .run_req       (run_req[1]),
      .on_time_we    (wr_en && addr == CH2_ON_TIME_ADDR),
      .on_time_wdata (wdata[5:0]),
      .regs_default  (regs_default),
      .state         (ch2_state),
      .on_time       (ch2_on_time)
   );

   a_load_watchdog_off: assert property (@(posedge clk) disable iff (sys_rst)
      code_load |=> !watchdog_enable) else $error("watchdog on after load code");
   a_detect_watchdog_on: assert property (@(posedge clk) disable iff (sys_rst)
      code_detect |=> watchdog_enable) else $error("watchdog off after detect code");
   a_reset_reads_zero: assert property (@(posedge clk) disable iff (sys_rst)
      rd_en && addr == SOFT_RESET_COMMAND_ADDR |=> rdata == 8'h00)
      else $error("reset register read nonzero");
   a_load_channels: assert property (@(posedge clk) disable iff (sys_rst)
      code_load && stand_alone |=> ch1_state == SRCR_CH_LOAD && ch2_state == SRCR_CH_LOAD)
      else $error("channels not in load");
   a_defaults_restored: assert property (@(posedge clk) disable iff (sys_rst)
      regs_default |=> ch1_on_time == ON_TIME_RST && ch2_on_time == ON_TIME_RST)
      else $error("on-time not restored");
   a_pc_kept: assert property (@(posedge clk) disable iff (sys_rst)
      regs_default && !status_rd |=> $stable(power_cycle_indicator))
      else $error("power-cycle bit changed by reset code");
   a_flags_cleared: assert property (@(posedge clk) disable iff (sys_rst)
      status_rd && !wdt_timeout |=> command_watchdog_timeout_flags == WDT_FLAGS_RST)
      else $error("timeout flags not cleared");
   a_other_ignored: assert property (@(posedge clk) disable iff (sys_rst)
      wr_en && addr == SOFT_RESET_COMMAND_ADDR && !regs_default |=> $stable(watchdog_enable))
      else $error("other value changed watchdog");

   // named steps of the return-to-detect handshake: a status read, then the second code
   sequence s_status_read;
      status_rd && !regs_default;
   endsequence

   sequence s_detect_standalone;
      code_detect && stand_alone;
   endsequence

   sequence s_idle_cycle;
      !regs_default && !status_rd;
   endsequence

   // in stand-alone mode a read directly followed by the second code sends both channels to detect
   a_read_then_detect: assert property (@(posedge clk) disable iff (sys_rst)
      s_status_read ##1 s_detect_standalone
      |=> ch1_state == SRCR_CH_DETECT && ch2_state == SRCR_CH_DETECT)
      else $error("channels not in detect after read and code");

   // read, one quiet cycle, then the second code: the read is still remembered
   a_read_gap_detect: assert property (@(posedge clk) disable iff (sys_rst)
      s_status_read ##1 s_idle_cycle ##1 s_detect_standalone
      |=> ch1_state == SRCR_CH_DETECT && ch2_state == SRCR_CH_DETECT)
      else $error("channels not in detect after read, gap and code");

   // in stand-alone mode any armed second code moves the channels whatever run requests say
   a_detect_channels: assert property (@(posedge clk) disable iff (sys_rst)
      s_detect_standalone and status_read_seen
      |=> ch1_state == SRCR_CH_DETECT && ch2_state == SRCR_CH_DETECT)
      else $error("armed detect code ignored");

   // a status read arms the detect path
   a_read_arms_detect: assert property (@(posedge clk) disable iff (sys_rst)
      s_status_read |=> status_read_seen)
      else $error("status read not remembered");

   // every reset code uses up the remembered status read
   a_code_disarms: assert property (@(posedge clk) disable iff (sys_rst)
      regs_default |=> !status_read_seen)
      else $error("status read kept after reset code");

   // without a prior status read the second code leaves the channels alone
   a_unarmed_detect_held: assert property (@(posedge clk) disable iff (sys_rst)
      code_detect && stand_alone && !status_read_seen && run_req == 2'b00
      |=> $stable(ch1_state) && $stable(ch2_state))
      else $error("unarmed detect code moved a channel");

   // outside stand-alone mode neither code moves the channel states; both still restore the on-time codes
   a_hosted_states_kept: assert property (@(posedge clk) disable iff (sys_rst)
      regs_default && !stand_alone && run_req == 2'b00
      |=> $stable(ch1_state) && $stable(ch2_state))
      else $error("reset code moved channel outside stand-alone");

   // the second code restores the on-time registers as well
   a_detect_defaults: assert property (@(posedge clk) disable iff (sys_rst)
      code_detect |=> ch1_on_time == ON_TIME_RST && ch2_on_time == ON_TIME_RST)
      else $error("on-time not restored by second code");

   // other values written to the command address leave channels and codes as they are
   a_other_states_kept: assert property (@(posedge clk) disable iff (sys_rst)
      wr_en && addr == SOFT_RESET_COMMAND_ADDR && !regs_default && run_req == 2'b00
      |=> $stable(ch1_state) && $stable(ch2_state) && $stable(ch1_on_time)
          && $stable(ch2_on_time))
      else $error("other value changed a channel");

   // an on-time write lands unchanged in its channel
   a_on_time_write: assert property (@(posedge clk) disable iff (sys_rst)
      wr_en && addr == CH1_ON_TIME_ADDR |=> ch1_on_time == $past(wdata[5:0]))
      else $error("on-time code not taken");

   // a timeout in the same cycle as a status read still leaves the flags set
   a_flag_set_wins: assert property (@(posedge clk) disable iff (sys_rst)
      wdt_timeout |=> command_watchdog_timeout_flags == 2'b11)
      else $error("timeout flags lost");

   // read data is zero whenever no read was taken
   a_rdata_idle: assert property (@(posedge clk) disable iff (sys_rst)
      !rd_en |=> rdata == 8'h00)
      else $error("read data not zero when idle");
endmodule // srcr_top
